// file: logic/dcrr_defs.svh
// Register offsets, field positions, reset values and counts of the calibration register bank
`ifndef DCRR_DEFS_SVH
`define DCRR_DEFS_SVH
`define DCRR_AW 5
`define DCRR_ADDR_CAL_CTRL 5'h0E
`define DCRR_ADDR_CAL_STAT 5'h0F
`define DCRR_ADDR_MEM_ADDR 5'h10
`define DCRR_ADDR_MEM_DATA 5'h11
`define DCRR_ADDR_MEM_CMD 5'h12
`define DCRR_ADDR_RT_CTRL 5'h14
`define DCRR_ADDR_VERSION 5'h1F
// Calibration control fields
`define DCRR_CC_PRELQ 7
`define DCRR_CC_PRELI 6
`define DCRR_CC_SELQ 5
`define DCRR_CC_SELI 4
`define DCRR_CC_CLKEN 3
`define DCRR_CC_DIV 2:0
`define DCRR_CC_RESET 8'h00
// Status fields
`define DCRR_ST_DONEQ 7
`define DCRR_ST_DONEI 6
// Memory command fields
`define DCRR_MC_CLRQ 7
`define DCRR_MC_CLRI 6
`define DCRR_MC_START 4
`define DCRR_MC_WR 3
`define DCRR_MC_RD 2
`define DCRR_MC_DEFQ 1
`define DCRR_MC_DEFI 0
// Retimer control fields
`define DCRR_RT_PHQ 7:6
`define DCRR_RT_SEARCH 4
`define DCRR_RT_REACQ 3
`define DCRR_RT_OVR 2
`define DCRR_RT_PHI 1:0
// Values and counts
`define DCRR_PRELOAD_DEF 6'h20
`define DCRR_REF_LOC 6'h01
`define DCRR_Q_BANK 5
`define DCRR_ACQ_LIMIT 128
`define DCRR_CAL_TICKS 32
`define DCRR_DIV_TOP 3'h7
`define DCRR_SPI_INSTR 5'h07
`define DCRR_SPI_LAST 5'h0F
`define DCRR_SPI_DONE 5'h10
`define DCRR_SPI_RDBIT 7
`endif

// file: logic/dcrr_pkg.sv
// Types shared by the calibration register bank
package dcrr_pkg;
	typedef enum logic [1:0] {
		DCRR_MEM_UNCAL = 2'h0,
		DCRR_MEM_SELF = 2'h1,
		DCRR_MEM_USER = 2'h2
	} dcrr_mem_state_t;
	typedef enum logic [0:0] {
		DCRR_CAL_IDLE = 1'h0,
		DCRR_CAL_RUN = 1'h1
	} dcrr_cal_state_t;
endpackage

// file: logic/dcrr_coef_mem.sv
// Static calibration coefficient memory, registered read port
`timescale 1ns/100ps
module dcrr_coef_mem #(
	parameter int AW = 6,
	parameter int DW = 6
) (
	input wire logic clk, // Converter clock
	input wire logic resetn, // Async reset, active low
	input wire logic we, // Write strobe
	input wire logic [AW-1:0] addr, // Location
	input wire logic [DW-1:0] wdata, // Write data
	output logic [DW-1:0] rdata // Registered read data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;

	// Array itself has no reset, so it maps onto plain storage
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// Read every cycle; caller picks the cycle it wants
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[addr];
		end
	end

	assign rdata = rdata_ff;
endmodule

// file: logic/dcrr_regs.sv
// Calibration, coefficient memory and retimer register bank behind a serial port
`timescale 1ns/100ps
`include "dcrr_defs.svh"
module dcrr_regs #(
	parameter int ACQ_CYCLES = `DCRR_ACQ_LIMIT,
	parameter int CAL_TICKS = `DCRR_CAL_TICKS,
	parameter logic [7:0] HW_VERSION = 8'h5A // Arbitrary value
) (
	input wire logic clk, // Converter clock, 50 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic spi_sclk, // Serial clock, sampled
	input wire logic spi_cs_n, // Serial select, active low
	input wire logic sdio_in, // Serial data in
	output logic sdio_out, // Serial data out
	output logic sdio_oe, // High while driving sdio
	input wire logic [1:0] i_phase_detect, // I phase detector result
	input wire logic [1:0] q_phase_detect, // Q phase detector result
	output logic [1:0] i_retimer_sel, // Phase used by I retimer
	output logic [1:0] q_retimer_sel, // Phase used by Q retimer
	output logic retimer_searching, // Retimer acquiring
	output logic cal_clk, // Divided calibration clock
	output logic i_cal_active, // I self-calibration running
	output logic q_cal_active, // Q self-calibration running
	output logic [5:0] i_cal_preload, // I preload reference
	output logic [5:0] q_cal_preload, // Q preload reference
	output logic i_coef_default, // Pulse: restore I defaults
	output logic q_coef_default // Pulse: restore Q defaults
);
	// ---- serial port state
	logic sclk_prev_ff;
	logic [4:0] bit_cnt_ff;
	logic [7:0] instr_ff;
	logic [7:0] shift_ff;
	logic [7:0] rd_shift_ff;
	logic sdo_ff;
	logic wr_stb_ff;
	logic [4:0] wr_addr_ff;
	logic [7:0] wr_data_ff;

	// ---- register state
	logic [7:0] cal_ctrl_ff;
	logic i_done_ff;
	logic q_done_ff;
	dcrr_pkg::dcrr_mem_state_t i_mstate_ff;
	dcrr_pkg::dcrr_mem_state_t q_mstate_ff;
	logic [5:0] mem_addr_ff;
	logic [5:0] mem_data_ff;
	logic rd_pend_ff;
	logic [5:0] user_ref_ff;
	logic override_ff;
	logic reacq_ff;
	logic [1:0] forced_ph_ff;
	logic [1:0] i_ph_ff;
	logic [1:0] q_ph_ff;
	logic search_ff;
	logic [7:0] acq_cnt_ff;
	logic [7:0] div_cnt_ff;
	logic cal_clk_ff;
	dcrr_pkg::dcrr_cal_state_t cal_st_ff;
	dcrr_pkg::dcrr_cal_state_t nxt_cal_st;
	logic [7:0] tick_cnt_ff;
	logic i_cal_run_ff;
	logic q_cal_run_ff;
	logic i_def_ff;
	logic q_def_ff;
	logic [1:0] i_sel_ff;
	logic [1:0] q_sel_ff;

	// ---- serial decode
	wire sclk_rise = spi_sclk && !sclk_prev_ff;
	wire sclk_fall = !spi_sclk && sclk_prev_ff;
	wire is_read = instr_ff[`DCRR_SPI_RDBIT];
	wire in_data = bit_cnt_ff > `DCRR_SPI_INSTR;
	wire instr_end = sclk_rise && (bit_cnt_ff == `DCRR_SPI_INSTR);
	wire data_end = sclk_rise && (bit_cnt_ff == `DCRR_SPI_LAST);
	wire [7:0] instr_next = {shift_ff[6:0], sdio_in};
	wire [7:0] rd_data;

	// Serial clock is sampled on clk, so it must run well below clk/4
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff <= spi_sclk;
		end
	end

	// Bit counter and input shifter; one instruction and one data byte per frame, no streaming
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_ff <= 5'h00;
			shift_ff <= 8'h00;
			instr_ff <= 8'h00;
		end else if (spi_cs_n) begin
			bit_cnt_ff <= 5'h00;
		end else if (sclk_rise && bit_cnt_ff != `DCRR_SPI_DONE) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
			shift_ff <= instr_next;
			if (instr_end) begin
				instr_ff <= instr_next;
			end
		end
	end

	// Write strobe once the data byte is complete
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= 5'h00;
			wr_data_ff <= 8'h00;
		end else begin
			wr_stb_ff <= !spi_cs_n && data_end && !is_read;
			if (data_end) begin
				wr_addr_ff <= instr_ff[`DCRR_AW-1:0];
				wr_data_ff <= instr_next;
			end
		end
	end

	// Read byte captured at end of instruction, shifted out on falling edges
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_shift_ff <= 8'h00;
			sdo_ff <= 1'b0;
		end else if (!spi_cs_n && instr_end) begin
			rd_shift_ff <= rd_data;
		end else if (!spi_cs_n && sclk_fall && in_data && is_read) begin
			sdo_ff <= rd_shift_ff[7];
			rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
		end
	end

	assign sdio_out = sdo_ff;
	assign sdio_oe = !spi_cs_n && in_data && is_read;

	// ---- register address decode
	wire [4:0] rd_addr = instr_next[`DCRR_AW-1:0];
	wire wr_cc = wr_stb_ff && wr_addr_ff == `DCRR_ADDR_CAL_CTRL;
	wire wr_ma = wr_stb_ff && wr_addr_ff == `DCRR_ADDR_MEM_ADDR;
	wire wr_md = wr_stb_ff && wr_addr_ff == `DCRR_ADDR_MEM_DATA;
	wire wr_mc = wr_stb_ff && wr_addr_ff == `DCRR_ADDR_MEM_CMD;
	wire wr_rt = wr_stb_ff && wr_addr_ff == `DCRR_ADDR_RT_CTRL;
	wire cmd_clr_q = wr_mc && wr_data_ff[`DCRR_MC_CLRQ];
	wire cmd_clr_i = wr_mc && wr_data_ff[`DCRR_MC_CLRI];
	wire cmd_start = wr_mc && wr_data_ff[`DCRR_MC_START];
	wire cmd_mwr = wr_mc && wr_data_ff[`DCRR_MC_WR];
	wire cmd_mrd = wr_mc && wr_data_ff[`DCRR_MC_RD];
	wire cmd_def_q = wr_mc && wr_data_ff[`DCRR_MC_DEFQ];
	wire cmd_def_i = wr_mc && wr_data_ff[`DCRR_MC_DEFI];
	wire mwr_q = cmd_mwr && mem_addr_ff[`DCRR_Q_BANK];

	// Readback mux; unmapped offsets read zero, command register is write-only
	wire [7:0] rt_rd = {q_ph_ff, 1'b0, search_ff, reacq_ff, override_ff,
		override_ff ? forced_ph_ff : i_ph_ff};
	wire [7:0] st_rd = {q_done_ff, i_done_ff, 2'b00, q_mstate_ff, i_mstate_ff};
	assign rd_data =
		(rd_addr == `DCRR_ADDR_CAL_CTRL) ? cal_ctrl_ff :
		(rd_addr == `DCRR_ADDR_CAL_STAT) ? st_rd :
		(rd_addr == `DCRR_ADDR_MEM_ADDR) ? {2'b00, mem_addr_ff} :
		(rd_addr == `DCRR_ADDR_MEM_DATA) ? {2'b00, mem_data_ff} :
		(rd_addr == `DCRR_ADDR_RT_CTRL) ? rt_rd :
		(rd_addr == `DCRR_ADDR_VERSION) ? HW_VERSION :
		8'h00;

	// Calibration control register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_ctrl_ff <= `DCRR_CC_RESET;
		end else if (wr_cc) begin
			cal_ctrl_ff <= wr_data_ff;
		end
	end

	// ---- coefficient memory access
	wire [5:0] mem_rdata;
	wire load_ref = cmd_mwr && mem_addr_ff == `DCRR_REF_LOC;

	// Address and data fields; a fetch lands one cycle after the command
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_addr_ff <= 6'h00;
			mem_data_ff <= 6'h00;
			rd_pend_ff <= 1'b0;
		end else begin
			rd_pend_ff <= cmd_mrd;
			if (wr_ma) begin
				mem_addr_ff <= wr_data_ff[5:0];
			end
			if (rd_pend_ff) begin
				mem_data_ff <= mem_rdata;
			end else if (wr_md) begin
				mem_data_ff <= wr_data_ff[5:0];
			end
		end
	end

	// Copy of the user reference location, so preload needs no read port
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			user_ref_ff <= `DCRR_PRELOAD_DEF;
		end else if (load_ref) begin
			user_ref_ff <= mem_data_ff;
		end
	end

	dcrr_coef_mem #(.AW(6), .DW(6)) u_mem (
		.clk(clk),
		.resetn(resetn),
		.we(cmd_mwr),
		.addr(mem_addr_ff),
		.wdata(mem_data_ff),
		.rdata(mem_rdata)
	);

	// Preload selection
	assign q_cal_preload = cal_ctrl_ff[`DCRR_CC_PRELQ] ? user_ref_ff : `DCRR_PRELOAD_DEF;
	assign i_cal_preload = cal_ctrl_ff[`DCRR_CC_PRELI] ? user_ref_ff : `DCRR_PRELOAD_DEF;

	// ---- calibration clock divider
	wire cal_en = cal_ctrl_ff[`DCRR_CC_CLKEN];
	wire [2:0] div_bit = `DCRR_DIV_TOP - cal_ctrl_ff[`DCRR_CC_DIV];
	wire [7:0] div_mask = 8'hFF >> cal_ctrl_ff[`DCRR_CC_DIV];
	wire cal_tick = cal_en && ((div_cnt_ff & div_mask) == div_mask);

	// Period is 2^(8-code) clocks: 256 down to 2 by halving
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_ff <= 8'h00;
			cal_clk_ff <= 1'b0;
		end else begin
			div_cnt_ff <= cal_en ? div_cnt_ff + 8'h01 : 8'h00;
			cal_clk_ff <= cal_en && div_cnt_ff[div_bit];
		end
	end

	assign cal_clk = cal_clk_ff;

	// ---- self-calibration sequencer
	wire cal_sel_any = cal_ctrl_ff[`DCRR_CC_SELQ] || cal_ctrl_ff[`DCRR_CC_SELI];
	wire cal_finish = cal_st_ff == dcrr_pkg::DCRR_CAL_RUN && cal_tick
		&& tick_cnt_ff == 8'(CAL_TICKS - 1);

	// Once started, the sequence only advances on calibration clock ticks, so it stalls when held off
	always_comb begin
		nxt_cal_st = cal_st_ff;
		case (cal_st_ff)
			dcrr_pkg::DCRR_CAL_IDLE: begin
				if (cmd_start && cal_sel_any) begin
					nxt_cal_st = dcrr_pkg::DCRR_CAL_RUN;
				end
			end
			dcrr_pkg::DCRR_CAL_RUN: begin
				if (cal_finish) begin
					nxt_cal_st = dcrr_pkg::DCRR_CAL_IDLE;
				end
			end
			default: begin
				nxt_cal_st = dcrr_pkg::DCRR_CAL_IDLE;
			end
		endcase
	end

	// Channels chosen at start are frozen for the whole run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_st_ff <= dcrr_pkg::DCRR_CAL_IDLE;
			tick_cnt_ff <= 8'h00;
			i_cal_run_ff <= 1'b0;
			q_cal_run_ff <= 1'b0;
		end else begin
			cal_st_ff <= nxt_cal_st;
			if (cal_st_ff == dcrr_pkg::DCRR_CAL_IDLE) begin
				tick_cnt_ff <= 8'h00;
				i_cal_run_ff <= cmd_start && cal_ctrl_ff[`DCRR_CC_SELI];
				q_cal_run_ff <= cmd_start && cal_ctrl_ff[`DCRR_CC_SELQ];
			end else if (cal_finish) begin
				i_cal_run_ff <= 1'b0;
				q_cal_run_ff <= 1'b0;
			end else if (cal_tick) begin
				tick_cnt_ff <= tick_cnt_ff + 8'h01;
			end
		end
	end

	assign i_cal_active = i_cal_run_ff;
	assign q_cal_active = q_cal_run_ff;

	// Done flags: a finish in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_done_ff <= 1'b0;
			q_done_ff <= 1'b0;
		end else begin
			i_done_ff <= (cal_finish && i_cal_run_ff) || (i_done_ff && !cmd_clr_i);
			q_done_ff <= (cal_finish && q_cal_run_ff) || (q_done_ff && !cmd_clr_q);
		end
	end

	// Memory state; a default request overrides other updates in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_mstate_ff <= dcrr_pkg::DCRR_MEM_UNCAL;
			q_mstate_ff <= dcrr_pkg::DCRR_MEM_UNCAL;
		end else begin
			if (cmd_def_i) begin
				i_mstate_ff <= dcrr_pkg::DCRR_MEM_UNCAL;
			end else if (cmd_mwr && !mwr_q) begin
				i_mstate_ff <= dcrr_pkg::DCRR_MEM_USER;
			end else if (cal_finish && i_cal_run_ff) begin
				i_mstate_ff <= dcrr_pkg::DCRR_MEM_SELF;
			end
			if (cmd_def_q) begin
				q_mstate_ff <= dcrr_pkg::DCRR_MEM_UNCAL;
			end else if (mwr_q) begin
				q_mstate_ff <= dcrr_pkg::DCRR_MEM_USER;
			end else if (cal_finish && q_cal_run_ff) begin
				q_mstate_ff <= dcrr_pkg::DCRR_MEM_SELF;
			end
		end
	end

	// Default pulses to the coefficient hardware
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_def_ff <= 1'b0;
			q_def_ff <= 1'b0;
		end else begin
			i_def_ff <= cmd_def_i;
			q_def_ff <= cmd_def_q;
		end
	end

	assign i_coef_default = i_def_ff;
	assign q_coef_default = q_def_ff;

	// ---- retimer control
	wire new_ovr = wr_data_ff[`DCRR_RT_OVR];
	wire reacq_rise = wr_rt && wr_data_ff[`DCRR_RT_REACQ] && !reacq_ff;
	wire acq_last = acq_cnt_ff == 8'(ACQ_CYCLES - 1);

	// Override, reacquire level and forced phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			override_ff <= 1'b0;
			reacq_ff <= 1'b0;
			forced_ph_ff <= 2'h0;
		end else if (wr_rt) begin
			override_ff <= new_ovr;
			reacq_ff <= wr_data_ff[`DCRR_RT_REACQ];
			if (new_ovr) begin
				forced_ph_ff <= wr_data_ff[`DCRR_RT_PHI];
			end
		end
	end

	// Search starts at reset release and on a rising reacquire write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			search_ff <= 1'b1;
			acq_cnt_ff <= 8'h00;
			i_ph_ff <= 2'h0;
			q_ph_ff <= 2'h0;
		end else if (reacq_rise) begin
			search_ff <= 1'b1;
			acq_cnt_ff <= 8'h00;
		end else if (search_ff) begin
			acq_cnt_ff <= acq_cnt_ff + 8'h01;
			if (acq_last) begin
				search_ff <= 1'b0;
				i_ph_ff <= i_phase_detect;
				q_ph_ff <= q_phase_detect;
			end
		end
	end

	// Phases applied to the retimers; old choice holds during a search
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			i_sel_ff <= 2'h0;
			q_sel_ff <= 2'h0;
		end else begin
			i_sel_ff <= override_ff ? forced_ph_ff : i_ph_ff;
			q_sel_ff <= override_ff ? forced_ph_ff : q_ph_ff;
		end
	end

	assign i_retimer_sel = i_sel_ff;
	assign q_retimer_sel = q_sel_ff;
	assign retimer_searching = search_ff;
endmodule

// file: tb/dcrr_regs_properties.sv
// Port-level properties of the calibration register bank
`timescale 1ns/100ps
module dcrr_regs_properties #(
	parameter int ACQ_CYCLES = 128
) (
	input wire logic clk, // Converter clock
	input wire logic resetn, // Async reset, active low
	input wire logic spi_cs_n, // Frame select
	input wire logic sdio_oe, // Serial drive enable
	input wire logic [1:0] i_phase_detect, // I detector
	input wire logic [1:0] q_phase_detect, // Q detector
	input wire logic [1:0] i_retimer_sel, // I phase used
	input wire logic [1:0] q_retimer_sel, // Q phase used
	input wire logic retimer_searching, // Acquiring
	input wire logic cal_clk, // Calibration clock
	input wire logic i_cal_active, // I run
	input wire logic q_cal_active, // Q run
	input wire logic [5:0] i_cal_preload, // I preload
	input wire logic [5:0] q_cal_preload, // Q preload
	input wire logic i_coef_default, // I default pulse
	input wire logic q_coef_default // Q default pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [15:0] search_len_ff;
	logic [15:0] nxt_search_len;
	// Length of the running search; one extra edge allowed for release sampling
	assign nxt_search_len = retimer_searching ? search_len_ff + 16'h0001 : 16'h0000;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			search_len_ff <= 16'h0000;
		end else begin
			search_len_ff <= nxt_search_len;
		end
	end
	sequence search_end;
		retimer_searching ##1 !retimer_searching;
	endsequence
	search_len_a: assert property (search_len_ff <= ACQ_CYCLES + 1) else $error("search too long");
	reset_state_a: assert property ($rose(resetn) |-> retimer_searching && !cal_clk && !i_cal_active && !q_cal_active)
		else $error("bad state after reset");
	preload_rst_a: assert property ($rose(resetn) |-> i_cal_preload == 6'h20 && q_cal_preload == 6'h20)
		else $error("preload not 32");
	// Phase is captured at the last search edge and reaches the retimer one edge later
	phase_load_a: assert property (search_end |=> i_retimer_sel == $past(i_phase_detect, 2)
		&& q_retimer_sel == $past(q_phase_detect, 2)) else $error("phase not taken");
	oe_frame_a: assert property (spi_cs_n |-> !sdio_oe) else $error("drive outside frame");
	qdef_pulse_a: assert property ($rose(q_coef_default) |=> !q_coef_default) else $error("q pulse long");
	idef_pulse_a: assert property ($rose(i_coef_default) |=> !i_coef_default) else $error("i pulse long");
	cal_clock_enable_run_a: assert property (q_cal_active |-> ##[0:300] $changed(cal_clk)) else $error("cal clock idle");
endmodule

// file: tb/dcrr_spi_host.sv
// Serial host model that sends one frame at a time
`timescale 1ns/100ps
module dcrr_spi_host (
	input wire logic clk, // Bank clock
	output logic sclk, // Serial clock, idle low
	output logic cs_n, // Frame select
	output logic sdo, // Data to device
	input wire logic sdi // Data from device
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdo = 1'b0;
	end
	// Halves of 3 clk so the device sees every edge; read data taken before each rise
	task automatic xfer(input logic rd, input logic [4:0] ad, input logic [7:0] d, output logic [7:0] q);
		logic [15:0] w;
		w = {rd, 2'h0, ad, d};
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b0;
			sdo <= (rd && i < 8) ? ~sdo : w[i]; // Released line toggles
			repeat (3) @(posedge clk);
			if (i < 8) q[i] = sdi;
			sclk <= 1'b1;
			repeat (3) @(posedge clk);
		end
		sclk <= 1'b0;
		cs_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule

// file: tb/dac_cal_retimer_regs_test.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/100ps
`include "dcrr_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module dac_cal_retimer_regs_test;
	logic clk, resetn, sclk, cs_n, sdi, sdo, oe, srch, cal_clock_enable, iact, qact, idef, qdef, sdio_rx, qu;
	logic [1:0] idet, qdet, isel, qsel;
	logic [5:0] ipre, qpre, a;
	logic [7:0] rdata, d;
	int errors, check_count, n, p;
	int srch_n, idef_n, qdef_n, iact_n, qact_n;
	dcrr_spi_host u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdo(sdi), .sdi(sdio_rx));
	// Released line shows the inverse of the last bit, so a sample taken off the frame shows up
	assign sdio_rx = oe ? sdo : ~sdo;
	dcrr_regs #(.ACQ_CYCLES(8), .CAL_TICKS(2)) i_dut (.clk(clk), .resetn(resetn), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .sdio_in(sdi), .sdio_out(sdo), .sdio_oe(oe), .i_phase_detect(idet),
		.q_phase_detect(qdet), .i_retimer_sel(isel), .q_retimer_sel(qsel), .retimer_searching(srch),
		.cal_clk(cal_clock_enable), .i_cal_active(iact), .q_cal_active(qact), .i_cal_preload(ipre),
		.q_cal_preload(qpre), .i_coef_default(idef), .q_coef_default(qdef));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Event counters, written only here: short pulses may end before a frame returns
	always @(posedge clk) begin
		srch_n <= srch_n + int'(srch === 1'b1);
		idef_n <= idef_n + int'(idef === 1'b1);
		qdef_n <= qdef_n + int'(qdef === 1'b1);
		iact_n <= iact_n + int'(iact === 1'b1);
		qact_n <= qact_n + int'(qact === 1'b1);
	end
	function automatic int div_of(input logic [2:0] c);
		return 256 >> c;
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [7:0] v);
		logic [7:0] z;
		u_host.xfer(1'b0, ad, v, z);
	endtask
	task automatic rd(input logic [4:0] ad);
		u_host.xfer(1'b1, ad, 8'h00, rdata);
	endtask
	// Bounded wait for the search or a calibration run to finish
	task automatic wait_idle(input logic cal);
		n = 0;
		while ((cal ? (iact | qact) : srch) !== 1'b0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			errors++;
			print_verdict();
		end
	endtask
	// Clk cycles from one rise of the calibration clock to the next
	task automatic period(output int q);
		logic prev;
		int k;
		int t;
		q = 0;
		k = 0;
		t = 0;
		prev = cal_clock_enable;
		while (k < 2 && t < 600) begin
			@(posedge clk);
			t++;
			if (cal_clock_enable && !prev) k++;
			if (k == 1) q++;
			prev = cal_clock_enable;
		end
		if (k < 2) begin
			errors++;
			print_verdict();
		end
	endtask
	initial begin
		errors = 0;
		check_count = 0;
		resetn = 1'b0;
		qu = 1'b0;
		void'($urandom(32'h9549E2BE));
		idet = 2'($urandom);
		qdet = 2'($urandom);
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		wr(`DCRR_ADDR_VERSION, 8'hFF);
		rd(`DCRR_ADDR_VERSION);
		`CHK(rdata, 8'h5A)
		rd(5'h13);
		`CHK(rdata, 8'h00)
		wait_idle(1'b0);
		rd(`DCRR_ADDR_RT_CTRL);
		`CHK(rdata & 8'hD7, {qdet, 6'h00} | {6'h00, idet})
		$display("test version and readback done");
		d = {6'h00, 2'($urandom)};
		wr(`DCRR_ADDR_RT_CTRL, d | 8'h04); // One phase for both retimers
		`CHK({isel, qsel}, {d[1:0], d[1:0]})
		rd(`DCRR_ADDR_RT_CTRL);
		`CHK(rdata[1:0], d[1:0])
		wr(`DCRR_ADDR_RT_CTRL, 8'h00);
		qdet <= ~qdet;
		p = srch_n;
		wr(`DCRR_ADDR_RT_CTRL, 8'h08);
		`CHK(srch_n > p, 1'b1)
		wait_idle(1'b0);
		// Retimer select follows the captured phase one edge after the search ends
		repeat (2) @(posedge clk);
		`CHK({isel, qsel}, {idet, qdet})
		p = srch_n;
		wr(`DCRR_ADDR_RT_CTRL, 8'h08);
		`CHK(srch_n, p)
		$display("test override and reacquire done");
		// Location 1 last so it feeds the user preload
		for (int k = 0; k < 4; k++) begin
			a = (k == 3) ? 6'h01 : 6'($urandom);
			qu = qu | a[5];
			d = 8'($urandom) & 8'h3F;
			wr(`DCRR_ADDR_MEM_ADDR, {2'h0, a});
			wr(`DCRR_ADDR_MEM_DATA, d);
			wr(`DCRR_ADDR_MEM_CMD, 8'h08);
			wr(`DCRR_ADDR_MEM_DATA, ~d & 8'h3F);
			wr(`DCRR_ADDR_MEM_CMD, 8'h04);
			rd(`DCRR_ADDR_MEM_DATA);
			`CHK(rdata[5:0], d[5:0])
		end
		rd(`DCRR_ADDR_CAL_STAT);
		`CHK(rdata, {4'h0, qu ? 2'h2 : 2'h0, 2'h2})
		wr(`DCRR_ADDR_CAL_CTRL, 8'hC0);
		`CHK({ipre, qpre}, {d[5:0], d[5:0]})
		wr(`DCRR_ADDR_CAL_CTRL, 8'h40);
		`CHK({ipre, qpre}, {d[5:0], 6'h20})
		$display("test coefficient memory done");
		for (int c = 0; c < 8; c++) begin
			wr(`DCRR_ADDR_CAL_CTRL, 8'h08 | 8'(c));
			period(p);
			period(p);
			`CHK(p, div_of(3'(c)))
		end
		wr(`DCRR_ADDR_CAL_CTRL, 8'h07);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (cal_clock_enable !== 1'b0) n++;
		end
		`CHK(n, 0)
		$display("test calibration clock done");
		wr(`DCRR_ADDR_CAL_CTRL, 8'h3F);
		wr(`DCRR_ADDR_MEM_CMD, 8'h10);
		wait_idle(1'b1);
		`CHK({qact_n != 0, iact_n != 0}, 2'h3)
		rd(`DCRR_ADDR_CAL_STAT);
		`CHK(rdata, 8'hC5)
		wr(`DCRR_ADDR_MEM_CMD, 8'h80);
		rd(`DCRR_ADDR_CAL_STAT);
		`CHK(rdata, 8'h45)
		wr(`DCRR_ADDR_MEM_CMD, 8'h03);
		`CHK({qdef_n != 0, idef_n != 0}, 2'h3)
		rd(`DCRR_ADDR_CAL_STAT);
		`CHK(rdata, 8'h40)
		$display("test self-calibration done");
		print_verdict();
	end
endmodule
bind dcrr_regs dcrr_regs_properties #(.ACQ_CYCLES(ACQ_CYCLES)) u_props (.clk(clk), .resetn(resetn),
	.spi_cs_n(spi_cs_n), .sdio_oe(sdio_oe), .i_phase_detect(i_phase_detect), .q_phase_detect(q_phase_detect),
	.i_retimer_sel(i_retimer_sel), .q_retimer_sel(q_retimer_sel), .retimer_searching(retimer_searching),
	.cal_clk(cal_clk), .i_cal_active(i_cal_active), .q_cal_active(q_cal_active), .i_cal_preload(i_cal_preload),
	.q_cal_preload(q_cal_preload), .i_coef_default(i_coef_default), .q_coef_default(q_coef_default));
